/* File: design/dpwm_chan.sv */
// One pulse-width channel: period counter, duty shadow and compare
`timescale 1ns/1ps
module dpwm_chan (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic tick_i,
  input wire logic [dpwm_pkg::CNT_W-1:0] duty_i,
  output logic [dpwm_pkg::CNT_W-1:0] cnt_o,
  output logic [dpwm_pkg::CNT_W-1:0] shadow_o,
  output logic active_o,
  output logic wrap_o
);

  logic [dpwm_pkg::CNT_W-1:0] cnt_r;
  logic [dpwm_pkg::CNT_W-1:0] shadow_r;

  assign wrap_o = tick_i && (cnt_r == dpwm_pkg::CNT_MAX);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= dpwm_pkg::CNT_ZERO;
    end else if (clr_i) begin
      cnt_r <= dpwm_pkg::CNT_ZERO;
    end else if (tick_i) begin
      cnt_r <= cnt_r + dpwm_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shadow_r <= dpwm_pkg::RST_DUTY;
    end else if (clr_i || wrap_o) begin
      shadow_r <= duty_i;
    end
  end

  // active for the first shadow_r ticks of each 256-tick period
  assign active_o = cnt_r < shadow_r;
  assign cnt_o = cnt_r;
  assign shadow_o = shadow_r;

endmodule : dpwm_chan

/* File: design/dpwm_div.sv */
// Tick generator dividing the system clock by the programmed factor plus one
`timescale 1ns/1ps
module dpwm_div (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic [dpwm_pkg::CNT_W-1:0] factor_i,
  output logic tick_o
);

  logic [dpwm_pkg::CNT_W-1:0] cnt_r;

  assign tick_o = !clr_i && (cnt_r >= factor_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= dpwm_pkg::CNT_ZERO;
    end else if (clr_i || tick_o) begin
      cnt_r <= dpwm_pkg::CNT_ZERO;
    end else begin
      cnt_r <= cnt_r + dpwm_pkg::CNT_ONE;
    end
  end

endmodule : dpwm_div

/* File: design/dpwm_pkg.sv */
// Shared constants and types for the dual pulse-width generator
package dpwm_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CHAN_N = 2;
  localparam int unsigned CNT_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_DUTY2 = 8'h9B;
  localparam logic [ADDR_W-1:0] ADDR_DUTY1 = 8'h9C;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h9D;
  localparam logic [ADDR_W-1:0] ADDR_CLKDIV = 8'h9E;

  // Reset values
  localparam logic [DATA_W-1:0] RST_CTRL = 8'h02;
  localparam logic [DATA_W-1:0] RST_CLKDIV = 8'h00;
  localparam logic [DATA_W-1:0] RST_DUTY = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // Counter limits
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;

  // Control register field positions
  localparam int unsigned BIT_IRQ_EN = 7;
  localparam int unsigned BIT_POL2 = 6;
  localparam int unsigned BIT_POL1 = 5;
  localparam int unsigned BIT_FLAG = 4;
  localparam int unsigned BIT_OE2 = 3;
  localparam int unsigned BIT_OE1 = 2;
  localparam int unsigned BIT_CLR = 1;

  // Field order matches bit positions 7 down to 0
  typedef struct packed {
    logic irq_en;
    logic pol2;
    logic pol1;
    logic flag;
    logic oe2;
    logic oe1;
    logic clr_all;
    logic rsvd;
  } dpwm_ctrl_t;

endpackage : dpwm_pkg

/* File: design/dpwm_top.sv */
// Dual pulse-width generator top: registers, channels and pin drivers
//
// Operation
// - Channel one is at its active level for duty/256 of each period, from 0% to 99.6%.
// - Channel two does the same with its own duty value, independent of channel one.
// - A polarity bit (6 for channel two, 5 for channel one) set makes the pin idle high.
// - A channel's waveform reaches its pin only while its enable (bit 3 or bit 2) is set.
// - Control bit 7 gates the period-end flag onto the interrupt request.
// - The period-end flag, control bit 4, is set whenever a period completes.
// - The flag clears on a write of 1 to it or on a write of the channel-one duty.
// - While clear-all (bit 1, reset value 1) is set, counters are emptied and the duty buffer reloads from the duty registers.
// - The count clock is the system clock divided by the 8-bit divider register plus one.
`timescale 1ns/1ps
module dpwm_top (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [dpwm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dpwm_pkg::DATA_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [dpwm_pkg::DATA_W-1:0] rdata_o,
  output logic [dpwm_pkg::CHAN_N-1:0] pwm_o,
  output logic [dpwm_pkg::CHAN_N-1:0] pwm_oe_o,
  output logic irq_o
);

  // Reset release through two flops; assertion stays asynchronous
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  // Register state
  dpwm_pkg::dpwm_ctrl_t ctrl_r;
  logic [dpwm_pkg::DATA_W-1:0] duty1_r;
  logic [dpwm_pkg::DATA_W-1:0] duty2_r;
  logic [dpwm_pkg::DATA_W-1:0] clkdiv_r;
  logic [dpwm_pkg::DATA_W-1:0] rdata_r;
  logic [dpwm_pkg::DATA_W-1:0] rdata_nxt;

  // Bus decode
  logic wr_duty1;
  logic wr_duty2;
  logic wr_ctrl;
  logic wr_clkdiv;

  assign wr_duty1 = we_i && (addr_i == dpwm_pkg::ADDR_DUTY1);
  assign wr_duty2 = we_i && (addr_i == dpwm_pkg::ADDR_DUTY2);
  assign wr_ctrl = we_i && (addr_i == dpwm_pkg::ADDR_CTRL);
  assign wr_clkdiv = we_i && (addr_i == dpwm_pkg::ADDR_CLKDIV);

  // Channel signals, index 0 is channel one
  logic tick;
  logic [dpwm_pkg::CHAN_N-1:0][dpwm_pkg::CNT_W-1:0] chan_duty;
  logic [dpwm_pkg::CHAN_N-1:0][dpwm_pkg::CNT_W-1:0] chan_cnt;
  logic [dpwm_pkg::CHAN_N-1:0][dpwm_pkg::CNT_W-1:0] chan_shadow;
  logic [dpwm_pkg::CHAN_N-1:0] chan_active;
  logic [dpwm_pkg::CHAN_N-1:0] chan_wrap;
  logic [dpwm_pkg::CHAN_N-1:0] chan_pol;
  logic [dpwm_pkg::CHAN_N-1:0] chan_oe;
  logic period_end;

  assign chan_duty[0] = duty1_r;
  assign chan_duty[1] = duty2_r;
  assign chan_pol[0] = ctrl_r.pol1;
  assign chan_pol[1] = ctrl_r.pol2;
  assign chan_oe[0] = ctrl_r.oe1;
  assign chan_oe[1] = ctrl_r.oe2;

  // Both channels share one tick, so channel one's wrap marks the period end
  assign period_end = chan_wrap[0];

  // Duty registers; a write only fills the buffer, the channel loads it later
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      duty1_r <= dpwm_pkg::RST_DUTY;
    end else if (wr_duty1) begin
      duty1_r <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      duty2_r <= dpwm_pkg::RST_DUTY;
    end else if (wr_duty2) begin
      duty2_r <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clkdiv_r <= dpwm_pkg::RST_CLKDIV;
    end else if (wr_clkdiv) begin
      clkdiv_r <= wdata_i;
    end
  end

  // Plain control fields; clear-all comes up set so nothing runs before software
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r.irq_en <= dpwm_pkg::RST_CTRL[dpwm_pkg::BIT_IRQ_EN];
      ctrl_r.pol2 <= dpwm_pkg::RST_CTRL[dpwm_pkg::BIT_POL2];
      ctrl_r.pol1 <= dpwm_pkg::RST_CTRL[dpwm_pkg::BIT_POL1];
      ctrl_r.oe2 <= dpwm_pkg::RST_CTRL[dpwm_pkg::BIT_OE2];
      ctrl_r.oe1 <= dpwm_pkg::RST_CTRL[dpwm_pkg::BIT_OE1];
      ctrl_r.clr_all <= dpwm_pkg::RST_CTRL[dpwm_pkg::BIT_CLR];
    end else if (wr_ctrl) begin
      ctrl_r.irq_en <= wdata_i[dpwm_pkg::BIT_IRQ_EN];
      ctrl_r.pol2 <= wdata_i[dpwm_pkg::BIT_POL2];
      ctrl_r.pol1 <= wdata_i[dpwm_pkg::BIT_POL1];
      ctrl_r.oe2 <= wdata_i[dpwm_pkg::BIT_OE2];
      ctrl_r.oe1 <= wdata_i[dpwm_pkg::BIT_OE1];
      ctrl_r.clr_all <= wdata_i[dpwm_pkg::BIT_CLR];
    end
  end

  // Reserved bit is read-only zero
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r.rsvd <= 1'b0;
    end else begin
      ctrl_r.rsvd <= 1'b0;
    end
  end

  // clear by write one or channel-one duty write
  // A set in the same cycle as a clear wins so no period end is lost
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r.flag <= dpwm_pkg::RST_CTRL[dpwm_pkg::BIT_FLAG];
    end else if (period_end) begin
      ctrl_r.flag <= 1'b1;
    end else if ((wr_ctrl && wdata_i[dpwm_pkg::BIT_FLAG]) || wr_duty1) begin
      ctrl_r.flag <= 1'b0;
    end
  end

  dpwm_div u_div (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .clr_i(ctrl_r.clr_all),
    .factor_i(clkdiv_r),
    .tick_o(tick)
  );

  for (genvar g = 0; g < dpwm_pkg::CHAN_N; g++) begin : g_chan
    dpwm_chan u_chan (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .clr_i(ctrl_r.clr_all),
      .tick_i(tick),
      .duty_i(chan_duty[g]),
      .cnt_o(chan_cnt[g]),
      .shadow_o(chan_shadow[g]),
      .active_o(chan_active[g]),
      .wrap_o(chan_wrap[g])
    );

    // enable gates waveform
    // A disabled channel holds pwm_o at its idle level but drops pwm_oe_o, so the pin floats
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        pwm_o[g] <= 1'b0;
        pwm_oe_o[g] <= 1'b0;
      end else begin
        pwm_o[g] <= (chan_oe[g] && chan_active[g]) ^ chan_pol[g];
        pwm_oe_o[g] <= chan_oe[g];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= ctrl_r.irq_en && ctrl_r.flag;
    end
  end

  // Read mux; unmapped offsets and idle cycles read zero
  always_comb begin
    rdata_nxt = dpwm_pkg::READ_ZERO;
    if (re_i) begin
      case (addr_i)
        dpwm_pkg::ADDR_DUTY1: rdata_nxt = duty1_r;
        dpwm_pkg::ADDR_DUTY2: rdata_nxt = duty2_r;
        dpwm_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
        dpwm_pkg::ADDR_CLKDIV: rdata_nxt = clkdiv_r;
        default: rdata_nxt = dpwm_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= dpwm_pkg::READ_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

  // tick gap tracker
  // A divider write or clear-all cuts the gap, so that gap is not judged
  logic [dpwm_pkg::CNT_W-1:0] tick_gap_r;
  logic gap_valid_r;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_gap_r <= dpwm_pkg::CNT_ZERO;
      gap_valid_r <= 1'b0;
    end else if (tick || wr_clkdiv || ctrl_r.clr_all) begin
      tick_gap_r <= dpwm_pkg::CNT_ZERO;
      gap_valid_r <= tick && !wr_clkdiv;
    end else begin
      tick_gap_r <= tick_gap_r + dpwm_pkg::CNT_ONE;
    end
  end

  // Checks on the design's own behaviour

  a_chan_one_level: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    ($past(chan_active[0]) && $past(ctrl_r.oe1) && !$past(ctrl_r.pol1)) |-> pwm_o[0]
  ) else $error("channel one not high while active");

  a_chan_two_level: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (ctrl_r.oe2 && ctrl_r.pol2 && !chan_active[1]) |=> pwm_o[1]
  ) else $error("channel two not idle high outside duty");

  a_idle_polarity: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (!ctrl_r.oe1 && $stable(ctrl_r.pol1)) |=> (pwm_o[0] == $past(ctrl_r.pol1))
  ) else $error("disabled channel one not at idle level");

  a_enable_reach: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    $rose(ctrl_r.oe2) |=> pwm_oe_o[1]
  ) else $error("channel two enable did not reach pin");

  a_irq_gated: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (ctrl_r.irq_en && ctrl_r.flag) |=> irq_o
  ) else $error("enabled flag gave no request");

  a_irq_masked: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    !ctrl_r.irq_en |=> !irq_o
  ) else $error("request raised while disabled");

  a_flag_set: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (period_end && (chan_cnt[0] == dpwm_pkg::CNT_MAX)) |=>
      (ctrl_r.flag && chan_cnt[0] == dpwm_pkg::CNT_ZERO)
  ) else $error("period end did not set flag");

  a_flag_clear: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (wr_duty1 && !period_end) |=> !ctrl_r.flag
  ) else $error("duty one write did not clear flag");

  a_clear_hold: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    ctrl_r.clr_all |-> !tick ##1
      (chan_cnt[0] == dpwm_pkg::CNT_ZERO && chan_cnt[1] == dpwm_pkg::CNT_ZERO)
  ) else $error("counters not emptied under clear-all");

  a_div_spacing: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (tick && gap_valid_r) |-> (tick_gap_r == clkdiv_r)
  ) else $error("tick spacing differs from divider factor plus one");

  a_duty_boundary: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (!chan_wrap[1] && !ctrl_r.clr_all) |=> $stable(chan_shadow[1])
  ) else $error("channel two duty changed mid-period");

  a_chan_one_low: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (!chan_active[0] && ctrl_r.oe1 && !ctrl_r.pol1) |=> !pwm_o[0]
  ) else $error("channel one high outside duty");

  a_chan_two_high: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (chan_active[1] && ctrl_r.oe2 && !ctrl_r.pol2) |=> pwm_o[1]
  ) else $error("channel two not high inside duty");

  a_idle_two: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    !pwm_oe_o[1] |-> (pwm_o[1] == $past(ctrl_r.pol2))
  ) else $error("disabled channel two not at idle level");

  a_pin_enable: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    pwm_oe_o == $past(chan_oe)
  ) else $error("pin enables do not follow control");

  a_irq_drop: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    !ctrl_r.flag |=> !irq_o
  ) else $error("request raised without flag");

  a_flag_hold: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (!period_end && !wr_duty1 && !wr_ctrl) |=> $stable(ctrl_r.flag)
  ) else $error("flag changed without period end or clear");

  a_flag_w1c: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (wr_ctrl && wdata_i[dpwm_pkg::BIT_FLAG] && !period_end) |=> !ctrl_r.flag
  ) else $error("write of one did not clear flag");

  a_clear_load: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    ctrl_r.clr_all |=> (chan_shadow[0] == $past(duty1_r) && chan_shadow[1] == $past(duty2_r))
  ) else $error("duty buffer not refilled under clear-all");

  a_count_hold: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (!tick && !ctrl_r.clr_all) |=> $stable(chan_cnt[1])
  ) else $error("counter moved without a tick");

  a_count_step: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    tick |=> (chan_cnt[0] == $past(chan_cnt[0]) + dpwm_pkg::CNT_ONE)
  ) else $error("counter did not step on tick");

  a_shadow_wrap: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    chan_wrap[0] |=> (chan_shadow[0] == $past(duty1_r))
  ) else $error("channel one duty not loaded at period start");

endmodule : dpwm_top

/* File: tb/dpwm_rc_load.sv */
// Filter load model on the two pins: integrates each pin level over a window
`timescale 1ns/1ps
module dpwm_rc_load (
  input wire logic clk_i,
  input wire logic zero_i,
  input wire logic [dpwm_pkg::CHAN_N-1:0] pin_i,
  input wire logic [dpwm_pkg::CHAN_N-1:0] oe_i,
  output logic [15:0] high1_o,
  output logic [15:0] high2_o
);
  logic [dpwm_pkg::CHAN_N-1:0] node;
  logic [dpwm_pkg::CHAN_N-1:0] last_r = 2'b00;
  // Undriven pin floats, so it shows a toggling level and never a held copy
  assign node = (pin_i & oe_i) | (~last_r & ~oe_i);
  always @(posedge clk_i) begin
    last_r <= node;
    high1_o <= zero_i ? 16'h0000 : high1_o + 16'(node[0]);
    high2_o <= zero_i ? 16'h0000 : high2_o + 16'(node[1]);
  end
endmodule : dpwm_rc_load

/* File: tb/dpwm_top_bench.sv */
// Register-level bench for the dual pulse-width generator
`timescale 1ns/1ps
module dpwm_top_bench;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [dpwm_pkg::ADDR_W-1:0] addr_i = 8'h00;
  logic [dpwm_pkg::DATA_W-1:0] wdata_i = 8'h00;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic zero = 1'b1;
  logic [dpwm_pkg::DATA_W-1:0] rdata_o;
  logic [dpwm_pkg::CHAN_N-1:0] pwm_o;
  logic [dpwm_pkg::CHAN_N-1:0] pwm_oe_o;
  logic irq_o;
  logic irq_q = 1'b0;
  logic [15:0] h1;
  logic [15:0] h2;
  logic [15:0] rise_gap = 16'h0000;
  logic [7:0] tdiv [4] = '{8'h00, 8'h03, 8'h00, 8'h00};
  logic [7:0] tctl [4] = '{8'h0c, 8'h0c, 8'h6c, 8'h0c};
  logic [7:0] td1 [4] = '{8'h40, 8'h40, 8'h40, 8'h00};
  logic [7:0] td2 [4] = '{8'hc0, 8'hc0, 8'hc0, 8'hff};
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int last_rise = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  dpwm_top dpwm_top_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .pwm_o(pwm_o),
    .pwm_oe_o(pwm_oe_o), .irq_o(irq_o));
  dpwm_rc_load dpwm_rc_load_i (.clk_i(ref_clk_i), .zero_i(zero), .pin_i(pwm_o),
    .oe_i(pwm_oe_o), .high1_o(h1), .high2_o(h2));
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    we_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    re_i <= 1'b0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, rdata_o});
  endtask : rd
  // Window opens one edge after zero drops and spans n sampled edges
  task automatic meas(input int n);
    @(posedge ref_clk_i);
    zero <= 1'b1;
    @(posedge ref_clk_i);
    zero <= 1'b0;
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : meas
  task automatic wt(input logic v);
    int i;
    // Step off the edge so a just-launched request is read settled
    #1;
    for (i = 0; i < 600 && irq_o !== v; i++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chk("irq", {15'h0000, v}, {15'h0000, irq_o});
  endtask : wt
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    irq_q <= irq_o;
    if (irq_o === 1'b1 && irq_q === 1'b0) begin
      rise_gap <= 16'(cyc - last_rise);
      last_rise <= cyc;
    end
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    int p;
    logic [15:0] e1;
    logic [15:0] e2;
    repeat (4) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rd(8'h9d, 8'h02);
    rd(8'h9e, 8'h00);
    rd(8'h9f, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(8'h9e, tdiv[k]);
      wr(8'h9c, td1[k]);
      wr(8'h9b, td2[k]);
      wr(8'h9d, tctl[k]);
      rd(8'h9c, td1[k]);
      p = 256 * (tdiv[k] + 1);
      meas(2 * p);
      meas(p);
      e1 = 16'(tctl[k][5] ? p - td1[k] * (tdiv[k] + 1) : td1[k] * (tdiv[k] + 1));
      e2 = 16'(tctl[k][6] ? p - td2[k] * (tdiv[k] + 1) : td2[k] * (tdiv[k] + 1));
      chk("duty_one", e1, h1);
      chk("duty_two", e2, h2);
    end
    chk("oe_on", 16'h0003, {14'h0000, pwm_oe_o});
    wr(8'h9d, 8'h1c);
    repeat (300) @(posedge ref_clk_i);
    rd(8'h9d, 8'h1c);
    chk("irq_off", 16'h0000, {15'h0000, irq_o});
    wr(8'h9d, 8'h9c);
    wt(1'b0);
    wt(1'b1);
    wr(8'h9d, 8'h9c);
    rd(8'h9d, 8'h8c);
    wt(1'b0);
    wt(1'b1);
    wr(8'h9c, 8'h00);
    rd(8'h9d, 8'h8c);
    chk("period", 16'h0100, rise_gap);
    wr(8'h9d, 8'h1e);
    repeat (600) @(posedge ref_clk_i);
    rd(8'h9d, 8'h0e);
    wr(8'h9d, 8'h0c);
    repeat (300) @(posedge ref_clk_i);
    rd(8'h9d, 8'h1c);
    // Disabled pins must rest at the polarity idle level, not follow the counter
    wr(8'h9d, 8'h60);
    repeat (4) begin
      repeat (77) @(posedge ref_clk_i);
      #1;
      chk("idle", 16'h0003, {14'h0000, pwm_o});
    end
    chk("oe_off", 16'h0000, {14'h0000, pwm_oe_o});
    results();
  end
endmodule : dpwm_top_bench
